// file: src/sensor_i2c_defines.svh
// constants for the sensor two-wire target port
`ifndef SENSOR_I2C_DEFINES_SVH
`define SENSOR_I2C_DEFINES_SVH

// fixed upper four bits of the seven-bit target address
`define TGT_ADDR_HIGH 4'hC
// bit counter value at the last bit of a byte
`define LAST_BIT 3'h7
// field positions of the word sent from link to register side
`define REQ_WRITE_BIT 12
`define REQ_INDEX_HI 11
`define REQ_INDEX_LO 8
`define REQ_DATA_HI 7
`define REQ_DATA_LO 0
`define REQ_WIDTH 13
// reset value of the register pointer
`define POINTER_RESET 4'h0
// reference clock period and least clock stretch, in ns
`define REF_CLK_PERIOD_NS 40
`define STRETCH_DURATION_NS 60000
// least time rounds up to whole reference cycles
`define STRETCH_CYC ((`STRETCH_DURATION_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define STRETCH_CNT_W 11

`endif

// file: src/sensor_i2c_pkg.sv
// types shared by the sensor two-wire target port
package sensor_i2c_pkg;

  // protocol states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE     = 10'b0000000001,
    ST_ADDR     = 10'b0000000010,
    ST_ADDR_ACK = 10'b0000000100,
    ST_PTR      = 10'b0000001000,
    ST_PTR_ACK  = 10'b0000010000,
    ST_WDATA    = 10'b0000100000,
    ST_WDAT_ACK = 10'b0001000000,
    ST_FETCH    = 10'b0010000000,
    ST_TX       = 10'b0100000000,
    ST_TX_ACK   = 10'b1000000000
  } link_state_t;

endpackage

// file: src/i2c_sync2.sv
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
module i2c_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second one
  always_ff @(posedge clk) begin
    stage1 <= async;
    synced <= stage1;
  end

endmodule

// file: src/word_handshake.sv
// toggle handshake that carries one word between two clock domains
`timescale 1ns/1ps
module word_handshake #(
  parameter int WIDTH = 8
) (
  input wire logic srcClk,
  input wire logic srcRst,
  input wire logic srcSend,
  input wire logic [WIDTH-1:0] srcData,
  output logic srcBusy,
  input wire logic dstClk,
  input wire logic dstRst,
  output logic dstValid,
  output logic [WIDTH-1:0] dstData
);

  logic reqTgl;
  logic ackTgl;
  logic reqSync;
  logic reqSeen;
  logic ackSync;
  logic [WIDTH-1:0] holdData;

  // source side: data held stable while the toggle travels
  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      reqTgl <= 1'b0;
      holdData <= '0;
    end else if (srcSend && !srcBusy) begin
      reqTgl <= ~reqTgl;
      holdData <= srcData;
    end
  end

  assign srcBusy = reqTgl != ackSync;

  i2c_sync2 #(.WIDTH(1)) reqSyncer (
    .clk(dstClk),
    .async(reqTgl),
    .synced(reqSync)
  );

  // destination side: a toggle change means a new word
  always_ff @(posedge dstClk) begin
    if (dstRst) begin
      reqSeen <= 1'b0;
      dstValid <= 1'b0;
      dstData <= '0;
    end else begin
      reqSeen <= reqSync;
      dstValid <= reqSync != reqSeen;
      if (reqSync != reqSeen) begin
        dstData <= holdData;
      end
    end
  end

  assign ackTgl = reqSeen;

  i2c_sync2 #(.WIDTH(1)) ackSyncer (
    .clk(srcClk),
    .async(ackTgl),
    .synced(ackSync)
  );

endmodule

// file: src/sensor_i2c_target_port.sv
// two-wire target port: protocol engine on the link clock, register side on ref_clk
`timescale 1ns/1ps
`include "sensor_i2c_defines.svh"

// What this block does
// - falling data while clock high is START
// - rising data while clock high is STOP
// - bus idle only when both lines high
// - data changes only while clock is low
// - address is 1100 plus three pin-selected bits
// - acknowledge address only on exact match
// - eighth address bit: one reads, zero writes
// - acknowledge every received byte by pulling data low
// - hold acknowledge low past the following clock fall
// - master NAK ends read; data line stays released
// - START or STOP mid-byte abandons, releases data
// - byte after write address sets register pointer
// - pointer retained; reads start from it
// - stretch clock low after each read acknowledge
// - pointer low four bits only, upper bits zero
// - advance pointer after each acknowledged read byte
module sensor_i2c_target_port
  import sensor_i2c_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrLevelBit2,
  input wire logic addrLevelBit1,
  input wire logic addrLevelBit0,
  output logic busBusy,
  output logic regRead,
  output logic regWrite,
  output logic [3:0] regIndex,
  output logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic regReadValid
);

  // link clock domain: pins, protocol engine and pointer

  logic linkRst;
  logic sclS;
  logic sdaS;
  logic [2:0] addrLevel;
  logic sclPrev;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  link_state_t state;
  logic [2:0] bitCnt;
  logic [7:0] shift;
  logic byteDone;
  logic readDir;
  logic masterAck;
  logic dataLoaded;
  logic [3:0] pointer;
  logic linkSend;
  logic [`REQ_WIDTH-1:0] linkSendData;
  logic linkDataValid;
  logic [7:0] linkData;
  logic [6:0] ownAddr;

  // reset is carried into the link domain through a synchroniser
  i2c_sync2 #(.WIDTH(1)) rstSyncer (
    .clk(linkClk),
    .async(rst),
    .synced(linkRst)
  );

  // pins and address straps come from outside, two flops first
  i2c_sync2 #(.WIDTH(5)) pinSyncer (
    .clk(linkClk),
    .async({sclIn, sdaIn, addrLevelBit2, addrLevelBit1, addrLevelBit0}),
    .synced({sclS, sdaS, addrLevel})
  );

  // previous synced levels for edge detection
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  // edges and bus conditions, only on synchronised values
  assign sclRise = sclS && !sclPrev;
  assign sclFall = !sclS && sclPrev;
  assign startSeen = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopSeen = sclS && sclPrev && !sdaPrev && sdaS;

  // address pin selects the low three bits
  assign ownAddr = {`TGT_ADDR_HIGH, addrLevel};

  // busy from START until STOP; idle is set by the STOP alone, line levels are not watched otherwise
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      busBusy <= 1'b0;
    end else if (startSeen) begin
      busBusy <= 1'b1;
    end else if (stopSeen) begin
      busBusy <= 1'b0;
    end
  end

  // open-drain pins only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  // protocol engine; a START or STOP anywhere wins over the byte in flight
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      state <= ST_IDLE;
      bitCnt <= 3'h0;
      shift <= 8'h00;
      byteDone <= 1'b0;
      readDir <= 1'b0;
      masterAck <= 1'b0;
      dataLoaded <= 1'b0;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      linkSend <= 1'b0;
      linkSendData <= '0;
    end else begin
      linkSend <= 1'b0;
      if (startSeen) begin
        // a fresh address byte follows every START
        state <= ST_ADDR;
        bitCnt <= 3'h0;
        byteDone <= 1'b0;
        sdaOe <= 1'b0;
        sclOe <= 1'b0;
      end else if (stopSeen) begin
        state <= ST_IDLE;
        sdaOe <= 1'b0;
        sclOe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sdaOe <= 1'b0;
            sclOe <= 1'b0;
          end
          ST_ADDR, ST_PTR, ST_WDATA: begin
            // receive: sample on rise, data is stable while clock high
            if (sclRise) begin
              shift <= {shift[6:0], sdaS};
              bitCnt <= bitCnt + 3'h1;
              byteDone <= bitCnt == `LAST_BIT;
            end else if (sclFall && byteDone) begin
              byteDone <= 1'b0;
              bitCnt <= 3'h0;
              if (state == ST_ADDR) begin
                if (shift[7:1] == ownAddr) begin
                  sdaOe <= 1'b1;
                  readDir <= shift[0];
                  state <= ST_ADDR_ACK;
                end else begin
                  // not ours: stay silent until the next START
                  state <= ST_IDLE;
                end
              end else if (state == ST_PTR) begin
                sdaOe <= 1'b1;
                state <= ST_PTR_ACK;
              end else begin
                sdaOe <= 1'b1;
                linkSend <= 1'b1;
                linkSendData <= {1'b1, pointer, shift};
                state <= ST_WDAT_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            // ack held low until the ninth clock has fallen again
            if (sclFall) begin
              sdaOe <= 1'b0;
              if (readDir) begin
                sclOe <= 1'b1;
                linkSend <= 1'b1;
                linkSendData <= {1'b0, pointer, 8'h00};
                dataLoaded <= 1'b0;
                state <= ST_FETCH;
              end else begin
                state <= ST_PTR;
              end
            end
          end
          ST_PTR_ACK, ST_WDAT_ACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              state <= ST_WDATA;
            end
          end
          ST_FETCH: begin
            // clock held low until the register side releases the data
            if (linkDataValid && !dataLoaded) begin
              shift <= linkData;
              sdaOe <= !linkData[7];
              dataLoaded <= 1'b1;
              bitCnt <= 3'h0;
            end else if (dataLoaded) begin
              // first bit has had a cycle to settle before the clock may rise
              sclOe <= 1'b0;
              state <= ST_TX;
            end
          end
          ST_TX: begin
            // shift out on falls; master owes eight clocks here
            if (sclFall) begin
              if (bitCnt == `LAST_BIT) begin
                sdaOe <= 1'b0;
                state <= ST_TX_ACK;
              end else begin
                sdaOe <= !shift[6];
                shift <= {shift[6:0], 1'b0};
                bitCnt <= bitCnt + 3'h1;
              end
            end
          end
          ST_TX_ACK: begin
            if (sclRise) begin
              masterAck <= !sdaS;
            end else if (sclFall) begin
              if (masterAck) begin
                sclOe <= 1'b1;
                linkSend <= 1'b1;
                linkSendData <= {1'b0, pointer + 4'h1, 8'h00};
                dataLoaded <= 1'b0;
                state <= ST_FETCH;
              end else begin
                // end of data: line stays released for the master's STOP
                sdaOe <= 1'b0;
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
            sclOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // pointer survives between accesses; only low four bits are kept
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      pointer <= `POINTER_RESET;
    end else if (!startSeen && !stopSeen) begin
      if (state == ST_PTR && sclFall && byteDone) begin
        pointer <= shift[3:0];
      end else if (state == ST_TX_ACK && sclFall && masterAck) begin
        pointer <= pointer + 4'h1;
      end
    end
  end

  // crossings between the link clock and ref_clk

  logic refReqValid;
  logic [`REQ_WIDTH-1:0] refReqData;
  logic refSendBack;
  logic [7:0] refReadData;

  // link to register side: write data or a read request with index
  word_handshake #(.WIDTH(`REQ_WIDTH)) reqXfer (
    .srcClk(linkClk),
    .srcRst(linkRst),
    .srcSend(linkSend),
    .srcData(linkSendData),
    .srcBusy(),
    .dstClk(ref_clk),
    .dstRst(rst),
    .dstValid(refReqValid),
    .dstData(refReqData)
  );

  // register side back to link: one read byte after the stretch
  word_handshake #(.WIDTH(8)) dataXfer (
    .srcClk(ref_clk),
    .srcRst(rst),
    .srcSend(refSendBack),
    .srcData(refReadData),
    .srcBusy(),
    .dstClk(linkClk),
    .dstRst(linkRst),
    .dstValid(linkDataValid),
    .dstData(linkData)
  );

  // reference clock domain: register strobes and stretch timing

  logic fetchPending;
  logic haveData;
  logic [`STRETCH_CNT_W-1:0] stretchCnt;

  // strobes to the register file; one pulse per request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRead <= 1'b0;
      regWrite <= 1'b0;
      regIndex <= 4'h0;
      regWriteData <= 8'h00;
    end else begin
      regRead <= refReqValid && !refReqData[`REQ_WRITE_BIT];
      regWrite <= refReqValid && refReqData[`REQ_WRITE_BIT];
      if (refReqValid) begin
        regIndex <= refReqData[`REQ_INDEX_HI:`REQ_INDEX_LO];
        if (refReqData[`REQ_WRITE_BIT]) begin
          regWriteData <= refReqData[`REQ_DATA_HI:`REQ_DATA_LO];
        end
      end
    end
  end

  // read fetch: the byte goes back only after both data and the full stretch time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fetchPending <= 1'b0;
      haveData <= 1'b0;
      stretchCnt <= '0;
      refReadData <= 8'h00;
      refSendBack <= 1'b0;
    end else begin
      refSendBack <= 1'b0;
      if (refReqValid && !refReqData[`REQ_WRITE_BIT]) begin
        fetchPending <= 1'b1;
        haveData <= 1'b0;
        stretchCnt <= `STRETCH_CNT_W'(`STRETCH_CYC - 1);
      end else if (fetchPending) begin
        if (stretchCnt != '0) begin
          stretchCnt <= stretchCnt - `STRETCH_CNT_W'(1);
        end
        if (regReadValid && !haveData) begin
          refReadData <= regReadData;
          haveData <= 1'b1;
        end
        // the clock was already held low before the request reached here
        if (stretchCnt == '0 && haveData) begin
          refSendBack <= 1'b1;
          fetchPending <= 1'b0;
        end
      end
    end
  end

endmodule

// file: testbench/sensor_i2c_target_port_properties.sv
// assertion checker for the sensor two-wire target port
`timescale 1ns/1ps
module sensor_i2c_target_port_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic busBusy,
  input wire logic regRead,
  input wire logic regWrite
);
  // stretch length in ref_clk cycles; holds its count one cycle past the release
  logic [11:0] stretchCnt;
  always_ff @(posedge ref_clk) begin
    stretchCnt <= (rst || !sclOe) ? 12'h000 : stretchCnt + 12'h001;
  end

  chk_write_single: assert property (@(posedge ref_clk) disable iff (rst) regWrite |=> !regWrite)
    else $error("register write pulse longer than one cycle");
  chk_read_single: assert property (@(posedge ref_clk) disable iff (rst) regRead |=> !regRead)
    else $error("register read pulse longer than one cycle");
  chk_rw_exclusive: assert property (@(posedge ref_clk) disable iff (rst) !(regRead && regWrite))
    else $error("read and write requested together");
  chk_stretch_length: assert property (@(posedge ref_clk) disable iff (rst)
    (!sclOe && stretchCnt != 12'h000) |-> stretchCnt >= 12'h5DB)
    else $error("clock stretch shorter than required");
  chk_idle_released: assert property (@(posedge linkClk) disable iff (rst)
    (!busBusy && !$past(busBusy)) |-> (!sdaOe && !sclOe))
    else $error("line pulled while bus idle");
  chk_sda_moves_low: assert property (@(posedge linkClk) disable iff (rst) $changed(sdaOe) |-> !sclIn)
    else $error("data line changed while clock high");
  chk_ack_held: assert property (@(posedge linkClk) disable iff (rst) (sdaOe && sclIn) |=> sdaOe)
    else $error("data low released while clock high");
  chk_bit_before_release: assert property (@(posedge linkClk) disable iff (rst)
    $fell(sclOe) |-> ($stable(sdaOe) && busBusy))
    else $error("clock released with data bit still moving");
  chk_stretch_in_frame: assert property (@(posedge linkClk) disable iff (rst) sclOe |-> busBusy)
    else $error("clock held outside a frame");

  cov_write: cover property (@(posedge ref_clk) regWrite);
  cov_read: cover property (@(posedge ref_clk) regRead);
  cov_stretch_end: cover property (@(posedge linkClk) $fell(sclOe));
endmodule

bind sensor_i2c_target_port sensor_i2c_target_port_checker sensor_i2c_target_port_checker_i (
  .ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .sclIn(sclIn), .sclOe(sclOe),
  .sdaOe(sdaOe), .busBusy(busBusy), .regRead(regRead), .regWrite(regWrite)
);

// file: testbench/i2c_master_model.sv
// behavioural two-wire bus master on open-drain clock and data
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int HALF_NS = 1000
) (
  input wire logic scl,
  input wire logic sda,
  output logic sclDrv,
  output logic sdaDrv
);
  // released lines float high through the pull-ups
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  // one bit slot; data moves mid-low so the target never sees a false condition
  task automatic bitT(input logic v, output logic s);
    #(HALF_NS / 2) sdaDrv = v;
    #(HALF_NS / 2) sclDrv = 1'b1;
    for (int n = 0; n < 3000 && scl !== 1'b1; n++) #40; // bounded stretch wait
    #(HALF_NS / 2) s = sda;
    #(HALF_NS / 2) sclDrv = 1'b0;
  endtask
  task automatic startC();
    #(HALF_NS / 2) sdaDrv = 1'b1;
    #(HALF_NS / 2) sclDrv = 1'b1;
    #HALF_NS sdaDrv = 1'b0;
    #HALF_NS sclDrv = 1'b0;
  endtask
  // stop, then the bus free time before any new start
  task automatic stopC();
    #(HALF_NS / 2) sdaDrv = 1'b0;
    #(HALF_NS / 2) sclDrv = 1'b1;
    #HALF_NS sdaDrv = 1'b1;
    #(10 * HALF_NS);
  endtask
  task automatic wrByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bitT(b[i], ack);
    bitT(1'b1, ack); // ninth clock
  endtask
  task automatic rdByte(output logic [7:0] b, input logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) bitT(1'b1, b[i]); // eight clocks
    bitT(nak, s);
  endtask
endmodule

// file: testbench/sensor_i2c_target_port_tb.sv
// self-checking bench for the sensor two-wire target port
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); errTotal++; end end
module sensor_i2c_target_port_tb;
  logic ref_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst = 1'b1;
  logic sclDrv, sdaDrv, sclOut, sclOe, sdaOut, sdaOe, busBusy, regRead, regWrite;
  logic regReadValid = 1'b0;
  logic [2:0] addrLvl = 3'h0;
  logic [3:0] regIndex;
  logic [7:0] regWriteData;
  logic [7:0] regReadData = 8'h00;
  logic [7:0] regFile [16];
  logic [31:0] lfsr = 32'h7F66;
  logic [12:0] expQ [$];
  logic [12:0] expNote;
  int errTotal = 0;
  int comparisons = 0;
  // open-drain wires with pull-ups
  wire sclW = sclDrv & (~sclOe | sclOut);
  wire sdaW = sdaDrv & (~sdaOe | sdaOut);

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // link clock, unrelated in phase
  initial begin
    #7;
    forever #24 linkClk = ~linkClk;
  end

  sensor_i2c_target_port sensor_i2c_target_port_i (
    .ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrLevelBit2(addrLvl[2]), .addrLevelBit1(addrLvl[1]),
    .addrLevelBit0(addrLvl[0]), .busBusy(busBusy), .regRead(regRead), .regWrite(regWrite),
    .regIndex(regIndex), .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid)
  );
  i2c_master_model i2c_master_model_i (.scl(sclW), .sda(sdaW), .sclDrv(sclDrv), .sdaDrv(sdaDrv));

  // register file answers after a data-dependent wait; stale data is inverted
  initial begin
    forever begin
      @(posedge ref_clk);
      if (regRead === 1'b1) begin
        repeat (regFile[regIndex][1:0]) @(posedge ref_clk);
        #2 regReadValid = 1'b1;
        regReadData = regFile[regIndex];
        @(posedge ref_clk);
        #2 regReadValid = 1'b0;
        regReadData = ~regReadData;
      end
    end
  end

  // each register request takes the oldest note
  always @(posedge ref_clk) begin
    if (regWrite === 1'b1 || regRead === 1'b1) begin
      expNote = (expQ.size() > 0) ? expQ.pop_front() : 13'h1FFF;
      `CHK("register request", expNote, {regWrite, regIndex, regRead ? 8'h00 : regWriteData})
    end
  end

  task automatic summarize();
    if (errTotal == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the whole sequence needs about 1 ms
  initial begin
    #3000000;
    errTotal++;
    summarize();
  end

  initial begin
    logic ack;
    logic [7:0] got;
    logic [3:0] idx;
    for (int i = 0; i < 16; i++) begin
      lfsr = nextRand(lfsr);
      regFile[i] = lfsr[7:0];
    end
    repeat (6) @(posedge ref_clk);
    #2 rst = 1'b0;
    repeat (10) @(posedge linkClk);
    // every address level: pointer with junk upper bits, then one data byte (two at the last level)
    for (int lvl = 0; lvl < 8; lvl++) begin
      lfsr = nextRand(lfsr);
      @(posedge ref_clk);
      #2 addrLvl = lvl[2:0];
      repeat (4) @(posedge linkClk);
      expQ.push_back({1'b1, lfsr[11:8], lfsr[7:0]});
      i2c_master_model_i.startC();
      i2c_master_model_i.wrByte({4'hC, addrLvl, 1'b0}, ack);
      `CHK("address ack", 1'b0, ack)
      i2c_master_model_i.wrByte(lfsr[15:8], ack);
      `CHK("pointer ack", 1'b0, ack)
      i2c_master_model_i.wrByte(lfsr[7:0], ack);
      `CHK("data ack", 1'b0, ack)
      // last level sends a second byte to the same pointer
      if (lvl == 7) begin
        expQ.push_back({1'b1, lfsr[11:8], ~lfsr[7:0]});
        i2c_master_model_i.wrByte(~lfsr[7:0], ack);
        `CHK("second data ack", 1'b0, ack)
      end
      i2c_master_model_i.stopC();
    end
    // foreign address is ignored; stop and start mid-byte abandon the byte
    i2c_master_model_i.startC();
    i2c_master_model_i.wrByte({4'hC, addrLvl ^ 3'h1, 1'b0}, ack);
    `CHK("foreign address ack", 1'b1, ack)
    i2c_master_model_i.stopC();
    i2c_master_model_i.startC();
    repeat (3) i2c_master_model_i.bitT(1'b1, ack);
    i2c_master_model_i.stopC();
    i2c_master_model_i.startC();
    repeat (4) i2c_master_model_i.bitT(1'b1, ack);
    i2c_master_model_i.startC();
    i2c_master_model_i.wrByte({4'hC, addrLvl, 1'b0}, ack);
    `CHK("address ack after abandon", 1'b0, ack)
    i2c_master_model_i.wrByte(8'hFE, ack);
    i2c_master_model_i.stopC();
    // read from the kept pointer across the wrap; master refuses the third byte
    idx = 4'hE;
    expQ.push_back({1'b0, idx, 8'h00});
    i2c_master_model_i.startC();
    i2c_master_model_i.wrByte({4'hC, addrLvl, 1'b1}, ack);
    `CHK("read address ack", 1'b0, ack)
    for (int k = 0; k < 3; k++) begin
      i2c_master_model_i.rdByte(got, k == 2);
      `CHK("read byte", regFile[idx], got)
      idx = idx + 4'h1;
      if (k < 2) expQ.push_back({1'b0, idx, 8'h00});
    end
    repeat (6) @(posedge linkClk);
    #2;
    `CHK("data line after refusal", 1'b0, sdaOe)
    `CHK("clock after refusal", 1'b0, sclOe)
    `CHK("bus busy in frame", 1'b1, busBusy)
    i2c_master_model_i.stopC();
    repeat (20) @(posedge ref_clk);
    `CHK("pending notes", 0, expQ.size())
    `CHK("bus idle after stop", 1'b0, busBusy)
    `CHK("open drain levels", 2'b00, {sclOut, sdaOut})
    summarize();
  end
endmodule
